//--- verilog/wdnmi_timer.sv
`timescale 1ns/1ps
`default_nettype none
module wdnmi_timer
  import wdnmi_pkg::*;
#(
  parameter int OSC_DIV = WDNMI_OSC_DIV,
  parameter int CNT_WIDTH = WDNMI_CNT_WIDTH
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // low-speed oscillator pin
  input wire logic low_speed_oscillator_in,
  // i/o memory port
  input wire logic [15:0] io_addr_in,
  input wire logic [WDNMI_DATA_WIDTH-1:0] io_wdata_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  output logic [WDNMI_DATA_WIDTH-1:0] io_rdata_out,
  // cpu core side
  input wire logic cpu_mask_state_in,
  input wire logic cpu_halt_in,
  input wire logic nmi_ack_in,
  output logic nmi_req_out,
  output logic [15:0] nmi_vector_out,
  output logic halt_wake_out
);
  localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [CNT_WIDTH-1:0] CNT_LAST = '1;

  // refuse sizes the divider and counter cannot serve
  if (OSC_DIV < 2) begin : g_bad_div
    $error("OSC_DIV must be at least 2");
  end
  if (CNT_WIDTH < 2) begin : g_bad_cnt
    $error("CNT_WIDTH must be at least 2");
  end

  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic osc_prev;
    logic [DIV_W-1:0] div;
    logic [CNT_WIDTH-1:0] count;
    logic enable;
    logic pending;
    logic [WDNMI_DATA_WIDTH-1:0] rdata;
    logic [15:0] vector;
  } wdnmi_state_type;

  wdnmi_state_type state;
  wdnmi_state_type next_state;
  logic ctrl_sel;
  logic clear_wr;
  logic tick;
  logic overflow;

  // decode and tick generation from the synchronised oscillator edge
  // full address decode, so no alias of the control register answers
  assign ctrl_sel = (io_addr_in == WDNMI_CTRL_ADDR);
  assign clear_wr = ctrl_sel & io_wr_in & io_wdata_in[WDNMI_CLR_POS];
  assign tick = (state.osc_s2 & ~state.osc_prev) & (state.div == DIV_LAST);
  assign overflow = tick & state.enable & ~clear_wr & (state.count == CNT_LAST);

  always_comb begin
    next_state = state;
    // two flops before the edge detector; s1 feeds only s2
    next_state.osc_s1 = low_speed_oscillator_in;
    next_state.osc_s2 = state.osc_s1;
    next_state.osc_prev = state.osc_s2;
    if (state.osc_s2 & ~state.osc_prev) begin
      next_state.div = (state.div == DIV_LAST) ? '0 : DIV_W'(state.div + 1'b1);
    end
    // enable bit write
    if (ctrl_sel & io_wr_in) begin
      next_state.enable = io_wdata_in[WDNMI_EN_POS];
    end
    // clear beats the tick so counting restarts from zero; halt does not stop it
    if (clear_wr) begin
      next_state.count = '0;
    end else if (tick & state.enable) begin
      next_state.count = CNT_WIDTH'(state.count + 1'b1);
    end
    // disabled counter holds its value unless a clear write zeroes it
    // request flag: a new overflow wins over the acknowledge
    if (overflow) begin
      next_state.pending = 1'b1;
    end else if (nmi_ack_in & nmi_req_out) begin
      next_state.pending = 1'b0;
    end
    // read data: clear bit and upper bits always zero
    next_state.rdata = '0;
    if (ctrl_sel & io_rd_in) begin
      next_state.rdata[WDNMI_EN_POS] = state.enable;
    end
    // vector kept in a flop so the core sees a settled word
    next_state.vector = WDNMI_NMI_VECTOR;
    if (rst_in) begin
      next_state = '0;
      next_state.enable = WDNMI_EN_RESET;
    end
  end

  always_ff @(posedge mclk_in) begin
    state <= next_state;
  end

  // no interrupt enable flag gates this; only the cpu mask state holds it off
  assign nmi_req_out = state.pending & ~cpu_mask_state_in;
  assign halt_wake_out = nmi_req_out & cpu_halt_in;
  assign io_rdata_out = state.rdata;
  assign nmi_vector_out = state.vector;

  // checks
  property p_en_reset;
    @(posedge mclk_in) $past(rst_in) && !rst_in |-> state.enable && state.count == '0;
  endproperty
  a_en_reset: assert property (p_en_reset) else $error("enable not set after reset");

  property p_rd_bits;
    @(posedge mclk_in) disable iff (rst_in)
      ctrl_sel && io_rd_in |=> io_rdata_out == {2'b00, $past(state.enable), 1'b0};
  endproperty
  a_rd_bits: assert property (p_rd_bits) else $error("control read data wrong");

  property p_clear;
    @(posedge mclk_in) disable iff (rst_in) clear_wr |=> state.count == '0 && !$past(overflow);
  endproperty
  a_clear: assert property (p_clear) else $error("clear write did not zero counter");

  property p_freeze;
    @(posedge mclk_in) disable iff (rst_in) !state.enable && !clear_wr |=> $stable(state.count);
  endproperty
  a_freeze: assert property (p_freeze) else $error("disabled counter moved");

  property p_advance;
    @(posedge mclk_in) disable iff (rst_in)
      tick && state.enable && !clear_wr |=> state.count == CNT_WIDTH'($past(state.count) + 1'b1);
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not advance on tick");

  property p_overflow;
    @(posedge mclk_in) disable iff (rst_in) overflow |=> state.pending && state.count == '0;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow lost");

  property p_mask;
    @(posedge mclk_in) disable iff (rst_in)
      state.pending && cpu_mask_state_in |-> !nmi_req_out ##1 state.pending;
  endproperty
  a_mask: assert property (p_mask) else $error("request passed during mask state");

  property p_deliver;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(state.pending) && !cpu_mask_state_in |-> nmi_req_out && nmi_vector_out == WDNMI_NMI_VECTOR;
  endproperty
  a_deliver: assert property (p_deliver) else $error("request or vector wrong");

  property p_wake;
    @(posedge mclk_in) disable iff (rst_in) nmi_req_out && cpu_halt_in |-> halt_wake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("halt not released");

  property p_hold;
    @(posedge mclk_in) disable iff (rst_in) state.pending && !nmi_ack_in |=> state.pending;
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped before acknowledge");

  // counter moves only on a tick or a clear write
  property p_only_tick;
    @(posedge mclk_in) disable iff (rst_in) !tick && !clear_wr |=> $stable(state.count);
  endproperty
  a_only_tick: assert property (p_only_tick) else $error("counter moved without a tick");

  property p_halt_count;
    @(posedge mclk_in) disable iff (rst_in)
      cpu_halt_in && tick && state.enable && !clear_wr |=> state.count != $past(state.count);
  endproperty
  a_halt_count: assert property (p_halt_count) else $error("counter stalled during halt");

  // register port behaviour
  property p_en_write;
    @(posedge mclk_in) disable iff (rst_in)
      ctrl_sel && io_wr_in |=> state.enable == $past(io_wdata_in[WDNMI_EN_POS]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable bit write lost");

  property p_rd_idle;
    @(posedge mclk_in) disable iff (rst_in) !(ctrl_sel && io_rd_in) |=> io_rdata_out == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");

  // request path
  property p_no_new_req;
    @(posedge mclk_in) disable iff (rst_in) !state.enable && !state.pending |=> !state.pending;
  endproperty
  a_no_new_req: assert property (p_no_new_req) else $error("request raised while disabled");

  property p_ack_clear;
    @(posedge mclk_in) disable iff (rst_in) nmi_req_out && nmi_ack_in && !overflow |=> !state.pending;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledged request not cleared");

  property p_one_overflow;
    @(posedge mclk_in) disable iff (rst_in) overflow |=> !overflow;
  endproperty
  a_one_overflow: assert property (p_one_overflow) else $error("overflow lasted two cycles");

  property p_vector;
    @(posedge mclk_in) disable iff (rst_in) !rst_in |=> nmi_vector_out == WDNMI_NMI_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("vector not held");

  // reset returns the block to counting from zero
  property p_reset_state;
    @(posedge mclk_in) rst_in |=> state.enable && state.count == '0 && !state.pending;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule
`default_nettype wire

//--- verilog/wdnmi_pkg.sv
// Summary of operation
// - counter advances on 256 Hz oscillator-derived tick
// - 10-bit counter; top stage overflow requests NMI
// - uncleared for 3-4 seconds raises NMI
// - enable bit resets to one, counting starts
// - counts during halt; NMI releases halt
// - NMI ignores interrupt enable flag
// - NMI held off during CPU mask state
// - NMI vectors to program address 0100H
// - enable bit D1 reads back, gates counting
// - writing one to D0 clears counter
// - clear bit always reads zero
// - bits D3 and D2 read zero
`default_nettype none
package wdnmi_pkg;
  localparam logic [15:0] WDNMI_CTRL_ADDR = 16'hff07;
  localparam int WDNMI_EN_POS = 1;
  localparam int WDNMI_CLR_POS = 0;
  localparam logic WDNMI_EN_RESET = 1'b1;
  localparam logic [15:0] WDNMI_NMI_VECTOR = 16'h0100;
  localparam int WDNMI_OSC_HZ = 32768;
  localparam int WDNMI_TICK_HZ = 256;
  localparam int WDNMI_OSC_DIV = WDNMI_OSC_HZ / WDNMI_TICK_HZ;
  localparam int WDNMI_CNT_WIDTH = 10;
  localparam int WDNMI_DATA_WIDTH = 4;
endpackage
`default_nettype wire

//--- tb/wdnmi_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdnmi_cpu_model (
  // clock
  input wire logic mclk_in,
  // from the block and the test
  input wire logic nmi_req_in,
  input wire logic ack_en_in,
  // to the block
  output logic osc_out,
  output logic ack_out
);
  // oscillator free-running, 8 mclk per period keeps ticks short
  initial begin
    osc_out = 1'b0;
    forever #100 osc_out = ~osc_out;
  end
  // no interrupt enable flag gates the request here
  initial begin
    ack_out = 1'b0;
    forever @(negedge mclk_in) ack_out <= ack_en_in & nmi_req_in & ~ack_out;
  end
endmodule
`default_nettype wire

//--- tb/wdnmi_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module wdnmi_timer_test;
  import wdnmi_pkg::*;
  logic mclk_in = 0, rst_in = 1, wr = 0, rd = 0, mask = 1, halt = 1, ack_en = 0, osc, ack, req, wake;
  logic [15:0] vec, addr = WDNMI_CTRL_ADDR;
  logic [3:0] wdata = 4'h0, rdata;
  int errors = 0, samples_checked = 0, cyc = 0, n;
  wdnmi_timer #(.OSC_DIV(2), .CNT_WIDTH(3)) i_wdnmi_timer (.mclk_in(mclk_in), .rst_in(rst_in),
    .low_speed_oscillator_in(osc), .io_addr_in(addr), .io_wdata_in(wdata), .io_wr_in(wr),
    .io_rd_in(rd), .io_rdata_out(rdata), .cpu_mask_state_in(mask), .cpu_halt_in(halt),
    .nmi_ack_in(ack), .nmi_req_out(req), .nmi_vector_out(vec), .halt_wake_out(wake));
  wdnmi_cpu_model i_wdnmi_cpu_model (.mclk_in(mclk_in), .nmi_req_in(req), .ack_en_in(ack_en),
    .osc_out(osc), .ack_out(ack));
  // clock and hang guard
  initial forever #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      results();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task idle(input int k);
    repeat (k) @(negedge mclk_in);
  endtask
  task wr_reg(input logic [3:0] d);
    @(negedge mclk_in);
    wdata = d;
    wr = 1'b1;
    @(negedge mclk_in);
    wr = 1'b0;
  endtask
  // data lands one cycle after the read edge
  task rd_chk(input logic [3:0] e);
    @(negedge mclk_in);
    rd = 1'b1;
    @(negedge mclk_in);
    rd = 1'b0;
    chk({12'h0, rdata}, {12'h0, e});
  endtask
  task results;
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    idle(3);
    rst_in = 1'b0;
    rd_chk(4'h2);
    addr = 16'hff06;
    wr_reg(4'h0);
    rd_chk(4'h0);
    addr = WDNMI_CTRL_ADDR;
    rd_chk(4'h2);
    idle(250);
    chk(req, 16'h0);
    mask = 1'b0;
    idle(1);
    chk(req, 16'h1);
    chk(vec, 16'h0100);
    chk(wake, 16'h1);
    halt = 1'b0;
    idle(1);
    chk(wake, 16'h0);
    ack_en = 1'b1;
    idle(3);
    chk(req, 16'h0);
    ack_en = 1'b0;
    wr_reg(4'hf);
    rd_chk(4'h2);
    repeat (6) begin
      idle(60);
      wr_reg(4'h3);
    end
    chk(req, 16'h0);
    // overflow needs eight ticks of sixteen cycles; first tick lands 1 to 16 cycles after the clear
    for (n = 0; n < 300 && req !== 1'b1; n++) idle(1);
    chk(req, 16'h1);
    chk(16'(n >= 113 && n <= 128), 16'h1);
    ack_en = 1'b1;
    idle(3);
    ack_en = 1'b0;
    wr_reg(4'h0);
    rd_chk(4'h0);
    idle(300);
    chk(req, 16'h0);
    // reset in mid-run must re-enable a disabled watchdog
    rst_in = 1'b1;
    idle(3);
    rst_in = 1'b0;
    rd_chk(4'h2);
    chk(req, 16'h0);
    results();
  end
endmodule
`default_nettype wire
